// ### design/flash_command_interface.sv
// flash command interface: apb registers, command sequencer, security, map
// Notes on behaviour
// - after erase-all completes, debug port runs erase-verify-all to confirm blankness.
// - commands loaded word by word through the indexed command object hi and lo byte registers.
// - no new command may be loaded while one is executing.
// - clearing complete flag launches; flag low while busy; flash writes then ignored.
// - program info row fields mapped only while its map bit is set.
// - data flash always mapped; its info region only with data map bit.
// - scratch ram mapped only with scratch map bit; rest reads reserved.
`timescale 1ns/100ps
`default_nettype none
`include "flash_cmd_cfg.svh"
module flash_command_interface
  import flash_cmd_pkg::*;
#(
  parameter int OBJ_WORDS = 6  // depth of the command object
) (
  input  wire logic        core_clk,       // bus clock
  input  wire logic        rst,            // sync reset, active high
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb enable
  input  wire logic        pwrite,         // apb direction
  input  wire logic [15:0] paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic      [31:0] prdata,         // apb read data
  output logic             pready,         // apb ready
  output logic             pslverr,        // apb error
  output logic             irq,            // level interrupt
  output logic             array_start,    // one-cycle array launch
  output logic      [7:0]  array_cmd,      // command code to array
  output logic      [22:0] array_addr,     // global address to array
  input  wire logic        array_done,     // array finished, one cycle
  input  wire logic        array_fail,     // verify found bits not erased
  input  wire logic        array_uncorr,   // uncorrectable fault seen
  input  wire logic [15:0] array_ecc,      // ecc result of last operation
  input  wire logic [22:0] fetch_gaddr,    // global address to decode
  output region_type       fetch_region,   // region hit
  output logic      [12:0] fetch_offset,   // offset in region
  output logic             secured         // security state
);
  map_decode_if mif ();

  cmd_state_type state_r;
  logic [15:0] obj_r [OBJ_WORDS];
  logic [2:0]  obj_idx_r;
  logic [7:0]  config_r;
  logic [7:0]  err_config_r;
  logic [7:0]  pprot_r;
  logic [7:0]  dprot_r;
  logic [7:0]  opt_r;
  logic [15:0] ecc_r;
  logic [2:0]  map_r;
  logic        cmd_done_r;
  logic        accerr_r;
  logic        fpviol_r;
  logic        mgstat1_r;
  logic        mgstat0_r;
  logic        secured_r;
  logic [2:0]  irq_st_r;
  logic [2:0]  irq_mask_r;
  logic [31:0] rdata_r;
  logic        err_r;
  logic        start_r;
  logic [7:0]  cmd_r;
  logic [22:0] addr_r;

  logic [13:0] idx;
  logic        wr;
  logic        setup;
  logic        mapped;
  logic        flash_wr;
  logic        launch;
  logic        ev_done;
  logic        ev_error;
  logic        ev_unsec;
  logic [7:0]  code;
  logic        need_open;
  logic        idx_bad;
  logic        prot_bad;
  logic [7:0]  status;
  logic [15:0] obj_word;
  logic        irq_wr;
  logic        mask_wr;
  logic        verify_pass;

  assign idx      = paddr[15:2];
  assign setup    = psel && !penable;
  assign wr       = psel && penable && pwrite;
  // writes to flash registers ignored while a command runs
  assign flash_wr = wr && cmd_done_r;
  assign launch   = flash_wr && idx == `IDX_STATUS && pwdata[`ST_CMD_DONE];
  assign code     = obj_r[0][15:8];
  // interrupt registers stay reachable while busy
  assign irq_wr   = wr && idx == `IDX_IRQ_STATUS;
  assign mask_wr  = wr && idx == `IDX_IRQ_MASK;

  // decoder of the global address map
  assign mif.gaddr       = fetch_gaddr;
  assign mif.pgm_map_en  = map_r[`MAP_PGM_INFO];
  assign mif.data_map_en = map_r[`MAP_DATA_INFO];
  assign mif.ram_map_en  = map_r[`MAP_SCRATCH];
  assign fetch_region    = mif.region;
  assign fetch_offset    = mif.offset;

  global_map_decoder u_dec (
    .m (mif.dec)
  );

  // address decode; unaligned addresses or indices outside the two register windows answer with an error
  always_comb begin
    mapped = (paddr[1:0] == 2'b00) &&
             ((idx >= `IDX_CONFIG && idx <= `IDX_RSVD_E) ||
              (idx >= `IDX_IRQ_STATUS && idx <= `IDX_SECURITY));
  end

  always_comb begin
    status = 8'h00;
    status[`ST_CMD_DONE] = cmd_done_r;
    status[`ST_ACCERR]  = accerr_r;
    status[`ST_FPVIOL]  = fpviol_r;
    status[`ST_MGBUSY]  = state_r != ST_IDLE;
    status[`ST_MGSTAT1] = mgstat1_r;
    status[`ST_MGSTAT0] = mgstat0_r;
  end

  // launch checks: the erase and verify commands carry no extra words
  always_comb begin
    need_open = code == `CMD_ERASE_ALL || code == `CMD_UNSECURE;
    idx_bad   = (code == `CMD_ERASE_ALL || code == `CMD_VERIFY_ALL ||
                 code == `CMD_UNSECURE) && obj_idx_r != `CMD_IDX_NONE;
    prot_bad  = need_open && !(pprot_r[`PROT_OPEN] && dprot_r[`PROT_OPEN]);
  end

  // word under the index; indices past the depth read zero
  always_comb begin
    obj_word = 16'h0000;
    if (int'(obj_idx_r) < OBJ_WORDS) begin
      obj_word = obj_r[obj_idx_r];
    end
  end

  // apb answers in the first access cycle; read data caught in setup
  assign pready  = 1'b1;
  assign prdata  = rdata_r;
  assign pslverr = err_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
      err_r   <= 1'b0;
    end else if (setup) begin
      err_r   <= !mapped;
      rdata_r <= 32'h0000_0000;
      case (idx)
        `IDX_CONFIG:      rdata_r[7:0]  <= config_r;
        `IDX_ERR_CONFIG:  rdata_r[7:0]  <= err_config_r;
        `IDX_STATUS:      rdata_r[7:0]  <= status;
        `IDX_PFLASH_PROT: rdata_r[7:0]  <= pprot_r;
        `IDX_DFLASH_PROT: rdata_r[7:0]  <= dprot_r;
        `IDX_CMD_OBJ_HI:  rdata_r[7:0]  <= obj_word[15:8];
        `IDX_CMD_OBJ_LO:  rdata_r[7:0]  <= obj_word[7:0];
        `IDX_ECC_HI:      rdata_r[7:0]  <= ecc_r[15:8];
        `IDX_ECC_LO:      rdata_r[7:0]  <= ecc_r[7:0];
        `IDX_NV_OPTIONS:  rdata_r[7:0]  <= opt_r;
        `IDX_IRQ_STATUS:  rdata_r[2:0]  <= irq_st_r;
        `IDX_IRQ_MASK:    rdata_r[2:0]  <= irq_mask_r;
        `IDX_MAP_CTRL:    rdata_r[2:0]  <= map_r;
        `IDX_CMD_INDEX:   rdata_r[2:0]  <= obj_idx_r;
        `IDX_SECURITY:    rdata_r[0]    <= secured_r;
        default:          rdata_r       <= 32'h0000_0000;
      endcase
    end
  end

  // configuration and protection registers, locked while busy
  always_ff @(posedge core_clk) begin
    if (rst) begin
      config_r     <= 8'h00;
      err_config_r <= 8'h00;
      pprot_r      <= `PROT_RESET;
      dprot_r      <= `PROT_RESET;
      opt_r        <= `OPT_RESET;
      map_r        <= 3'h0;
    end else if (flash_wr) begin
      case (idx)
        `IDX_CONFIG:      config_r     <= pwdata[7:0] & 8'h93;
        `IDX_ERR_CONFIG:  err_config_r <= pwdata[7:0] & 8'h03;
        `IDX_PFLASH_PROT: pprot_r      <= pwdata[7:0];
        `IDX_DFLASH_PROT: dprot_r      <= pwdata[7:0] & 8'h9F;
        `IDX_NV_OPTIONS:  opt_r        <= pwdata[7:0];
        `IDX_MAP_CTRL:    map_r        <= pwdata[2:0];
        default:          map_r        <= map_r;
      endcase
    end
  end

  // command object words, each word reached through the index
  always_ff @(posedge core_clk) begin
    if (rst) begin
      obj_idx_r <= 3'h0;
    end else if (flash_wr && idx == `IDX_CMD_INDEX) begin
      obj_idx_r <= pwdata[2:0];
    end
  end

  generate
    for (genvar w = 0; w < OBJ_WORDS; w++) begin : g_obj
      always_ff @(posedge core_clk) begin
        if (rst) begin
          obj_r[w] <= 16'h0000;
        end else if (flash_wr && obj_idx_r == 3'(w)) begin
          if (idx == `IDX_CMD_OBJ_HI) obj_r[w][15:8] <= pwdata[7:0];
          if (idx == `IDX_CMD_OBJ_LO) obj_r[w][7:0]  <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // command sequencer; a launch only arrives while idle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      start_r <= 1'b0;
      cmd_r   <= 8'h00;
      addr_r  <= 23'h000000;
    end else begin
      start_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (launch) state_r <= ST_CHECK;
        end
        ST_CHECK: begin
          if (idx_bad || prot_bad) begin
            state_r <= ST_DONE;
          end else begin
            start_r <= 1'b1;
            cmd_r   <= code;
            addr_r  <= {obj_r[0][6:0], obj_r[1]};
            state_r <= ST_ARRAY;
          end
        end
        ST_ARRAY: begin
          if (array_done) state_r <= ST_DONE;
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
        default:  state_r <= ST_IDLE;
      endcase
    end
  end

  // array side sees only registered values, never the bus
  assign array_start = start_r;
  assign array_cmd   = cmd_r;
  assign array_addr  = addr_r;

  // complete flag: low from launch until the operation ends
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_done_r <= 1'b1;
    end else if (launch) begin
      cmd_done_r <= 1'b0;
    end else if (state_r == ST_DONE) begin
      cmd_done_r <= 1'b1;
    end
  end

  // access and protection error flags: set by the sequencer, cleared by writing one; set wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      accerr_r  <= 1'b0;
      fpviol_r  <= 1'b0;
      mgstat1_r <= 1'b0;
      mgstat0_r <= 1'b0;
      ecc_r     <= 16'h0000;
    end else begin
      if (state_r == ST_CHECK && idx_bad) begin
        accerr_r <= 1'b1;
      end else if (flash_wr && idx == `IDX_STATUS && pwdata[`ST_ACCERR]) begin
        accerr_r <= 1'b0;
      end
      if (state_r == ST_CHECK && prot_bad && !idx_bad) begin
        fpviol_r <= 1'b1;
      end else if (flash_wr && idx == `IDX_STATUS && pwdata[`ST_FPVIOL]) begin
        fpviol_r <= 1'b0;
      end
      // verify result flags start clean for each launch
      if (launch) begin
        mgstat1_r <= 1'b0;
        mgstat0_r <= 1'b0;
      end else if (state_r == ST_ARRAY && array_done) begin
        mgstat1_r <= array_fail;
        mgstat0_r <= array_uncorr;
        ecc_r     <= array_ecc;
      end
    end
  end

  // a clean verify or unsecure result, seen with the done pulse
  assign verify_pass = state_r == ST_ARRAY && array_done && !array_fail &&
                       (cmd_r == `CMD_VERIFY_ALL || cmd_r == `CMD_UNSECURE);

  // security drops only on a passing verify or unsecure; failure keeps it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      secured_r <= `SECURED_RESET;
    end else if (verify_pass) begin
      secured_r <= 1'b0;
    end
  end

  // security state straight from its flop
  assign secured = secured_r;

  // interrupt events
  assign ev_done  = state_r == ST_DONE;
  assign ev_error = state_r == ST_CHECK && (idx_bad || prot_bad);
  assign ev_unsec = verify_pass && secured_r;

  // sticky interrupt status; a new event beats a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_st_r <= 3'h0;
    end else begin
      irq_st_r <= (irq_st_r & ~(irq_wr ? pwdata[2:0] : 3'h0))
                  | {ev_unsec, ev_error, ev_done};
    end
  end

  // mask stays writable while busy so software can quiet the line
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_mask_r <= 3'h0;
    end else if (mask_wr) begin
      irq_mask_r <= pwdata[2:0];
    end
  end

  // level output; masking hides a bit but keeps it sticky
  assign irq = |(irq_st_r & irq_mask_r);
endmodule
`default_nettype wire

// ### pkg/flash_cmd_cfg.svh
// offsets, field positions, reset values and codes of the flash command block
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH
// register indices; byte address is four times the index
`define IDX_CONFIG        14'h0104
`define IDX_ERR_CONFIG    14'h0105
`define IDX_STATUS        14'h0106
`define IDX_ERR_STATUS    14'h0107
`define IDX_PFLASH_PROT   14'h0108
`define IDX_DFLASH_PROT   14'h0109
`define IDX_CMD_OBJ_HI    14'h010A
`define IDX_CMD_OBJ_LO    14'h010B
`define IDX_RSVD_A        14'h010C
`define IDX_RSVD_B        14'h010D
`define IDX_ECC_HI        14'h010E
`define IDX_ECC_LO        14'h010F
`define IDX_NV_OPTIONS    14'h0110
`define IDX_RSVD_C        14'h0111
`define IDX_RSVD_E        14'h0113
`define IDX_IRQ_STATUS    14'h0120
`define IDX_IRQ_MASK      14'h0121
`define IDX_MAP_CTRL      14'h0122
`define IDX_CMD_INDEX     14'h0123
`define IDX_SECURITY      14'h0124
// status bit positions
`define ST_CMD_DONE       7
`define ST_ACCERR         5
`define ST_FPVIOL         4
`define ST_MGBUSY         3
`define ST_MGSTAT1        1
`define ST_MGSTAT0        0
// protection open bit, mapping control bits
`define PROT_OPEN         7
`define MAP_PGM_INFO      0
`define MAP_DATA_INFO     1
`define MAP_SCRATCH       2
// interrupt status bits
`define IRQ_DONE          0
`define IRQ_ERROR         1
`define IRQ_UNSECURED     2
// reset values
`define PROT_RESET        8'hFF
`define OPT_RESET         8'hFF
`define SECURED_RESET     1'b1
// command codes and their launch index
`define CMD_VERIFY_ALL    8'h01
`define CMD_ERASE_ALL     8'h08
`define CMD_UNSECURE      8'h0B
`define CMD_IDX_NONE      3'h0
// global address ranges
`define PGM_ID_LO         23'h40_0000
`define PGM_ID_HI         23'h40_0007
`define PGM_VER_LO        23'h40_00E8
`define PGM_VER_HI        23'h40_00E9
`define PGM_ONCE_LO       23'h40_0100
`define PGM_ONCE_HI       23'h40_013F
`define DF_LO             23'h10_0000
`define DF_HI             23'h10_1FFF
`define DF_INFO_LO        23'h12_0000
`define DF_INFO_HI        23'h12_007F
`define RAM_LO            23'h12_3D00
`define RAM_HI            23'h12_3FFF
`endif

// ### pkg/flash_cmd_pkg.sv
// types shared by the flash command block
package flash_cmd_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_ARRAY = 2'b10,
    ST_DONE  = 2'b11
  } cmd_state_type;

  typedef enum logic [2:0] {
    RG_NONE    = 3'b000,
    RG_DEV_ID  = 3'b001,
    RG_VERSION = 3'b010,
    RG_ONCE    = 3'b011,
    RG_DFLASH  = 3'b100,
    RG_DF_INFO = 3'b101,
    RG_SCRATCH = 3'b110
  } region_type;
endpackage

// ### pkg/map_decode_if.sv
// carrier between the command block and its global address decoder
`timescale 1ns/100ps
`default_nettype none
interface map_decode_if;
  import flash_cmd_pkg::*;
  logic [22:0] gaddr;
  logic        pgm_map_en;
  logic        data_map_en;
  logic        ram_map_en;
  region_type  region;
  logic [12:0] offset;
  modport dec (input gaddr, pgm_map_en, data_map_en, ram_map_en, output region, offset);
  modport ctl (output gaddr, pgm_map_en, data_map_en, ram_map_en, input region, offset);
endinterface
`default_nettype wire

// ### design/global_map_decoder.sv
// global address decoder for info rows, data flash and scratch ram
`timescale 1ns/100ps
`default_nettype none
`include "flash_cmd_cfg.svh"
module global_map_decoder
  import flash_cmd_pkg::*;
(
  map_decode_if.dec m  // decode request and answer
);
  // info rows and scratch ram only exist while their map bit is set
  always_comb begin
    m.region = RG_NONE;
    m.offset = 13'h0000;
    if (m.pgm_map_en && m.gaddr >= `PGM_ID_LO && m.gaddr <= `PGM_ID_HI) begin
      m.region = RG_DEV_ID;
      m.offset = 13'(m.gaddr - `PGM_ID_LO);
    end else if (m.pgm_map_en && m.gaddr >= `PGM_VER_LO && m.gaddr <= `PGM_VER_HI) begin
      m.region = RG_VERSION;
      m.offset = 13'(m.gaddr - `PGM_VER_LO);
    end else if (m.pgm_map_en && m.gaddr >= `PGM_ONCE_LO && m.gaddr <= `PGM_ONCE_HI) begin
      m.region = RG_ONCE;
      m.offset = 13'(m.gaddr - `PGM_ONCE_LO);
    end else if (m.gaddr >= `DF_LO && m.gaddr <= `DF_HI) begin
      m.region = RG_DFLASH;
      m.offset = 13'(m.gaddr - `DF_LO);
    end else if (m.data_map_en && m.gaddr >= `DF_INFO_LO && m.gaddr <= `DF_INFO_HI) begin
      m.region = RG_DF_INFO;
      m.offset = 13'(m.gaddr - `DF_INFO_LO);
    end else if (m.ram_map_en && m.gaddr >= `RAM_LO && m.gaddr <= `RAM_HI) begin
      m.region = RG_SCRATCH;
      m.offset = 13'(m.gaddr - `RAM_LO);
    end
  end
endmodule
`default_nettype wire

// ### verif/flash_array_model.sv
// behavioural flash array that answers launches after a chosen delay
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
  input  wire logic        core_clk,     // bus clock
  input  wire logic        rst,          // sync reset
  input  wire logic        array_start,  // launch pulse
  input  wire logic [7:0]  lat,          // cycles until done
  input  wire logic        fail_en,      // verify finds dirty bits
  output logic             array_done,   // finish pulse
  output logic             array_fail,   // verify result
  output logic             array_uncorr, // fault flag
  output logic      [15:0] array_ecc     // ecc result
);
  logic [7:0] cnt_r;
  // fail and fault lines toggle outside the done pulse so stale values never pass; ecc toggles every cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= 8'h00;
      array_done <= 1'b0;
      array_fail <= 1'b0;
      array_uncorr <= 1'b0;
      array_ecc <= 16'h0000;
    end else begin
      cnt_r <= array_start ? lat : (cnt_r != 8'h00 ? cnt_r - 8'h01 : 8'h00);
      array_done <= (cnt_r == 8'h01);
      array_fail <= (cnt_r == 8'h01) ? fail_en : ~array_fail;
      array_uncorr <= (cnt_r == 8'h01) ? 1'b0 : ~array_uncorr;
      array_ecc <= ~array_ecc;
    end
  end
endmodule
`default_nettype wire

// ### verif/flash_command_interface_assertions.sv
// port-level checks of the flash command block
`timescale 1ns/100ps
`default_nettype none
`include "flash_cmd_cfg.svh"
module flash_command_interface_assertions
  import flash_cmd_pkg::*;
#(
  parameter int OBJ_WORDS = 6  // depth of the command object
) (
  input wire logic        core_clk,     // bus clock
  input wire logic        rst,          // sync reset
  input wire logic        psel,         // apb select
  input wire logic        penable,      // apb enable
  input wire logic        pwrite,       // apb direction
  input wire logic [15:0] paddr,        // apb address
  input wire logic [31:0] pwdata,       // apb write data
  input wire logic [31:0] prdata,       // apb read data
  input wire logic        pready,       // apb ready
  input wire logic        pslverr,      // apb error
  input wire logic        irq,          // interrupt
  input wire logic        array_start,  // launch pulse
  input wire logic [7:0]  array_cmd,    // command code
  input wire logic [22:0] array_addr,   // global address
  input wire logic        array_done,   // array finished
  input wire logic        array_fail,   // verify failed
  input wire logic        array_uncorr, // fault
  input wire logic [15:0] array_ecc,    // ecc result
  input wire logic [22:0] fetch_gaddr,  // decode address
  input wire region_type  fetch_region, // decode region
  input wire logic [12:0] fetch_offset, // decode offset
  input wire logic        secured       // security state
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic busy_h;
  logic launch_w;
  assign launch_w = psel && penable && pwrite && paddr == 16'h0418 && pwdata[7];
  // array busy window seen from the pins
  always_ff @(posedge core_clk) begin
    if (rst) busy_h <= 1'b0;
    else if (array_start) busy_h <= 1'b1;
    else if (array_done) busy_h <= 1'b0;
  end
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_start_cause; array_start |-> $past(launch_w, 2); endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without launch");
  property p_no_start_busy; busy_h |-> !array_start; endproperty
  a_no_start_busy: assert property (p_no_start_busy) else $error("start while busy");
  property p_cmd_hold; busy_h |-> $stable(array_cmd) && $stable(array_addr); endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command moved while busy");
  property p_fail_keeps; array_done && array_fail && secured |=> secured; endproperty
  a_fail_keeps: assert property (p_fail_keeps) else $error("failed verify unsecured");
  property p_drop_cause; $fell(secured) |-> $past(array_done) && !$past(array_fail); endproperty
  a_drop_cause: assert property (p_drop_cause) else $error("unsecured without pass");
  property p_stays_open; !secured |=> !secured; endproperty
  a_stays_open: assert property (p_stays_open) else $error("security came back");
  property p_dflash;
    fetch_gaddr >= `DF_LO && fetch_gaddr <= `DF_HI |-> fetch_region == RG_DFLASH && fetch_offset == fetch_gaddr[12:0];
  endproperty
  a_dflash: assert property (p_dflash) else $error("data flash decode wrong");
  property p_scratch;
    fetch_region == RG_SCRATCH |-> fetch_gaddr >= `RAM_LO && fetch_gaddr <= `RAM_HI
      && fetch_offset == 13'(fetch_gaddr - `RAM_LO);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch decode wrong");
  property p_rsvd_row;
    fetch_gaddr >= 23'h40_0008 && fetch_gaddr <= 23'h40_00E7 |-> fetch_region == RG_NONE;
  endproperty
  a_rsvd_row: assert property (p_rsvd_row) else $error("reserved row decoded");
  property p_unmapped; psel && penable && paddr >= 16'h0450 && paddr <= 16'h047C |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped without error");
  c_start: cover property (array_start);
  c_unsecure: cover property ($fell(secured));
  c_scratch: cover property (fetch_region == RG_SCRATCH);
endmodule
bind flash_command_interface flash_command_interface_assertions #(.OBJ_WORDS(OBJ_WORDS)) chk_i (
  .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
  .array_start, .array_cmd, .array_addr, .array_done, .array_fail, .array_uncorr, .array_ecc,
  .fetch_gaddr, .fetch_region, .fetch_offset, .secured);
`default_nettype wire

// ### verif/flash_command_interface_tb_top.sv
// self-checking bench of the flash command block
`timescale 1ns/100ps
`default_nettype none
module flash_command_interface_tb_top;
  import flash_cmd_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, array_start, array_done, array_fail, array_uncorr, secured, fail_en = 1'b0;
  logic [7:0] array_cmd, lat = 8'h0A;
  logic [22:0] array_addr, fetch_gaddr = 23'h0;
  logic [15:0] array_ecc;
  logic [12:0] fetch_offset;
  region_type fetch_region;
  logic [32:0] expq[$];
  logic [32:0] e;
  int fail_count = 0, cmp_count = 0, starts = 0;
  integer seed = 32'hCFC3;
  logic [22:0] ga[8] = '{23'h40_0003, 23'h40_00E9, 23'h40_013F, 23'h40_0050,
                         23'h10_1FFF, 23'h12_007F, 23'h12_3D00, 23'h12_4000};
  logic [2:0] rg[8] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h4, 3'h5, 3'h6, 3'h0};
  logic [12:0] of[8] = '{13'h3, 13'h1, 13'h3F, 13'h0, 13'h1FFF, 13'h7F, 13'h0, 13'h0};
  int sb[8] = '{0, 0, 0, 0, 3, 1, 2, 0};
  logic [2:0] m;
  always #20 core_clk = ~core_clk;
  flash_command_interface uut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .array_start, .array_cmd, .array_addr, .array_done, .array_fail,
    .array_uncorr, .array_ecc, .fetch_gaddr, .fetch_region, .fetch_offset, .secured);
  flash_array_model model (.core_clk, .rst, .array_start, .lat, .fail_en, .array_done,
    .array_fail, .array_uncorr, .array_ecc);
  task results;
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; the monitor judges its answer from the queued note
  task apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic err);
    int n;
    n = 0;
    expq.push_back({err, d});
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin fail_count++; results; end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // load, launch, touch registers while busy for a good command only, then check the outcome
  task cmd(input logic [7:0] code, input logic [2:0] ix, input logic fl, good, input logic [31:0] st);
    logic [6:0] a;
    int s0, n;
    a = 7'($random(seed));
    s0 = starts;
    n = 0;
    fail_en <= fl;
    lat <= 8'(10 + ($random(seed) & 7));
    apb(1'b1, 16'h048C, {29'h0, ix}, 1'b0);
    apb(1'b1, 16'h0428, {24'h0, code}, 1'b0);
    apb(1'b1, 16'h042C, {25'h0, a}, 1'b0);
    apb(1'b1, 16'h0418, 32'h0000_0080, 1'b0);
    if (good) begin
      apb(1'b0, 16'h0418, 32'h0000_0008, 1'b0);
      apb(1'b1, 16'h0488, 32'h0, 1'b0);
      while (array_done !== 1'b1 && n < 200) begin @(posedge core_clk); n++; end
      if (n == 200) begin fail_count++; results; end
      chk("array_cmd", {24'h0, array_cmd}, {24'h0, code});
      chk("array_addr", {25'h0, array_addr[22:16]}, {25'h0, a});
    end
    repeat (3) @(posedge core_clk);
    if (!good) chk("starts", 32'(starts), 32'(s0));
    apb(1'b0, 16'h0418, st, 1'b0);
    apb(1'b0, 16'h0488, 32'h7, 1'b0);
  endtask
  // monitor: take the oldest note at each completed transfer
  always @(posedge core_clk) begin
    if (array_start === 1'b1) starts++;
    if (psel && penable && pready) begin
      e = expq.pop_front();
      chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
      if (!pwrite) chk("prdata", prdata, e[31:0]);
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, 16'h0420, 32'hFF, 1'b0);
    apb(1'b0, 16'h0490, 32'h1, 1'b0);
    apb(1'b0, 16'h0418, 32'h80, 1'b0);
    apb(1'b0, 16'h0430, 32'h0, 1'b0);
    apb(1'b0, 16'h0450, 32'h0, 1'b1);
    apb(1'b1, 16'h047C, 32'h0, 1'b1);
    apb(1'b1, 16'h0488, 32'h7, 1'b0);
    apb(1'b1, 16'h0484, 32'h1, 1'b0);
    cmd(`CMD_ERASE_ALL, 3'h0, 1'b0, 1'b1, 32'h80);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, 16'h0480, 32'h7, 1'b0);
    chk("irq", {31'h0, irq}, 32'h0);
    apb(1'b1, 16'h0484, 32'h0, 1'b0);
    cmd(`CMD_VERIFY_ALL, 3'h0, 1'b1, 1'b1, 32'h82);
    chk("secured", {31'h0, secured}, 32'h1);
    chk("irq", {31'h0, irq}, 32'h0);
    apb(1'b1, 16'h0484, 32'h1, 1'b0);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, 16'h0480, 32'h7, 1'b0);
    cmd(`CMD_VERIFY_ALL, 3'h0, 1'b0, 1'b1, 32'h80);
    apb(1'b0, 16'h0490, 32'h0, 1'b0);
    apb(1'b0, 16'h0480, 32'h5, 1'b0);
    apb(1'b1, 16'h0480, 32'h7, 1'b0);
    cmd(`CMD_ERASE_ALL, 3'h1, 1'b0, 1'b0, 32'hA0);
    apb(1'b1, 16'h0418, 32'h20, 1'b0);
    apb(1'b1, 16'h0420, 32'h7F, 1'b0);
    cmd(`CMD_UNSECURE, 3'h0, 1'b0, 1'b0, 32'h90);
    // random map settings against a table of boundary addresses
    repeat (12) begin
      m = 3'($random(seed));
      apb(1'b1, 16'h0488, {29'h0, m}, 1'b0);
      for (int i = 0; i < 8; i++) begin
        fetch_gaddr <= ga[i];
        @(posedge core_clk);
        chk("region", {29'h0, fetch_region}, (sb[i] == 3 || m[sb[i]]) ? {29'h0, rg[i]} : 32'h0);
        chk("offset", {19'h0, fetch_offset}, (sb[i] == 3 || m[sb[i]]) ? {19'h0, of[i]} : 32'h0);
      end
    end
    results;
  end
endmodule
`default_nettype wire
